// >>> hw/sample_exchange.v
// Processor-side sample exchange: input and output FIFOs, formatting
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "sample_exchange_consts.vh"
// Function
// - Input FIFO full flag raised at 1, 2, 3 or 6 samples per two-bit code.
// - Zero bit set forces reads of the second input register to zero.
// - Zero bit set forces reads of the first input register to zero.
// - Reset bit trims the second input FIFO to exactly one sample.
// - Reset bit trims the first input FIFO to exactly one sample.
// - Each 32-bit single-layout sample register carries only 20 meaningful sample bits.
// - Single layout: ~b19, b19, b19, b18..b0, then ten zero bits.
// - Packed layout: left bits 19..4 high half, right bits 19..4 low half.
// - With 16 or 18-bit samples, low bits read zero and writes ignore them.
// - Inverted MSB presents two's complement data as unsigned.
// - Every register path uses separate left and right FIFOs.
// - Right overrun drops that sample and suppresses the next left write.
// - Left overrun suppresses the next right write of that FIFO.
// - Right transmit underrun blocks the next left read strobe.
// - Left transmit underrun blocks the next right read strobe.
// - Input FIFOs are six samples deep with programmable full level.
// - Output sample registers respond at four consecutive word addresses.

module sample_exchange (
	input  wire         ref_clk,     // System clock, 100 MHz
	input  wire         reset,       // Synchronous reset, active high
	input  wire [7:0]   addr,        // Register byte address
	input  wire [31:0]  wdata,       // Register write data
	input  wire         wr_en,       // Write strobe
	input  wire         rd_en,       // Read strobe
	output reg  [31:0]  rdata,       // Read data, cycle after rd_en
	input  wire [99:0]  rx_data_l,   // Five receiver left samples
	input  wire [99:0]  rx_data_r,   // Five receiver right samples
	input  wire [4:0]   rx_stb_l,    // Receiver left sample strobes
	input  wire [4:0]   rx_stb_r,    // Receiver right sample strobes
	input  wire [2:0]   tx_rd_l,     // Transmit left read strobes a,b,c
	input  wire [2:0]   tx_rd_r,     // Transmit right read strobes a,b,c
	output reg  [59:0]  tx_data_l,   // Transmit left samples a,b,c
	output reg  [59:0]  tx_data_r,   // Transmit right samples a,b,c
	output wire [2:0]   in_full      // Input FIFO full flags a,b,c
);

	// ------------------------------------------------------------
	// Control and configuration
	// ------------------------------------------------------------
	reg  [23:0]  ctl_reg;
	reg  [1:0]   width_reg;
	reg  [19:0]  mask;
	wire [7:0]   rel = addr - `ADDR_SAMPLE_FIRST;
	wire         in_range = (addr >= `ADDR_SAMPLE_FIRST) &&
	                        (addr <= `ADDR_SAMPLE_LAST);
	wire [2:0]   grp = rel[6:4];
	wire         wr_smp = wr_en && in_range;
	wire         rd_smp = rd_en && in_range;

	always @* begin
		case (width_reg)
			`WIDTH_18: mask = `MASK_18;
			`WIDTH_16: mask = `MASK_16;
			default:   mask = `MASK_20;
		endcase
	end

	wire [3:0] sel_a = {ctl_reg[`CTL_A_SEL_HI],
	                    ctl_reg[`CTL_A_SEL_LO -: 3]};
	wire [3:0] sel_b = {ctl_reg[`CTL_B_SEL_HI],
	                    ctl_reg[`CTL_B_SEL_LO -: 3]};
	wire [3:0] sel_c = ctl_reg[`CTL_C_SEL_LO -: 4];
	wire [5:0] thr_codes = {ctl_reg[`CTL_C_THR_LO +: 2],
	                        ctl_reg[`CTL_B_THR_LO +: 2],
	                        ctl_reg[`CTL_A_THR_LO +: 2]};
	wire [2:0] trim_in = {ctl_reg[`CTL_C_RST], ctl_reg[`CTL_B_RST],
	                      ctl_reg[`CTL_A_RST]};

	// Written sample decoded from the single or packed layout
	wire [19:0] wr_single = {wdata[30], wdata[28:10]} & mask;
	wire [19:0] wr_pk_l   = {wdata[31:16], 4'h0} & mask;
	wire [19:0] wr_pk_r   = {wdata[15:0], 4'h0} & mask;

	// ------------------------------------------------------------
	// Twelve FIFOs: 0..5 input a,b,c left/right, 6..11 output
	// ------------------------------------------------------------
	reg  [11:0]  push;
	reg  [11:0]  pop;
	reg  [239:0] push_data;
	wire [239:0] head;
	wire [35:0]  fill;
	wire [11:0]  full;
	wire [11:0]  empty;

	genvar g;
	generate
		for (g = 0; g < 12; g = g + 1) begin : fifo
			reg [19:0] mem [0:5];
			reg [2:0]  wp_reg;
			reg [2:0]  rp_reg;
			reg [2:0]  cnt_reg;
			wire do_push = push[g] && (cnt_reg != `FIFO_DEPTH);
			wire do_pop  = pop[g] && (cnt_reg != 3'h0);
			wire trim    = (g < 6) ? trim_in[(g % 6) / 2] : 1'b0;
			wire [2:0] wp_inc = (wp_reg == `FIFO_LAST) ? 3'h0
			                    : wp_reg + 3'h1;
			wire [2:0] rp_inc = (rp_reg == `FIFO_LAST) ? 3'h0
			                    : rp_reg + 3'h1;
			assign head[g*20 +: 20]  = mem[rp_reg];
			assign fill[g*3 +: 3]    = cnt_reg;
			assign full[g]           = (cnt_reg == `FIFO_DEPTH);
			assign empty[g]          = (cnt_reg == 3'h0);
			always @(posedge ref_clk) begin
				if (do_push)
					mem[wp_reg] <= push_data[g*20 +: 20];
			end
			always @(posedge ref_clk) begin
				if (reset) begin
					wp_reg  <= 3'h0;
					rp_reg  <= 3'h0;
					cnt_reg <= 3'h0;
				end else if (trim && (cnt_reg > 3'h1)) begin
					wp_reg  <= rp_inc;
					cnt_reg <= 3'h1;
				end else begin
					if (do_push)
						wp_reg <= wp_inc;
					if (do_pop)
						rp_reg <= rp_inc;
					cnt_reg <= cnt_reg + {2'h0, do_push} - {2'h0, do_pop};
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Full-level flags of the input FIFOs
	// ------------------------------------------------------------
	generate
		for (g = 0; g < 3; g = g + 1) begin : level
			reg [2:0] thr;
			always @* begin
				case (thr_codes[g*2 +: 2])
					2'h0:    thr = `THR_0;
					2'h1:    thr = `THR_1;
					2'h2:    thr = `THR_2;
					default: thr = `THR_3;
				endcase
			end
			// Level flag follows the left fill, so it falls with reads
			assign in_full[g] = (fill[g*6 +: 3] >= thr);
		end
	endgenerate

	// ------------------------------------------------------------
	// Source streams: code 1/2 taps processor writes, 4..8 receivers
	// ------------------------------------------------------------
	reg  [179:0] src_l;
	reg  [179:0] src_r;
	reg  [8:0]   src_sl;
	reg  [8:0]   src_sr;
	wire         wa_l = wr_smp && (grp == `GRP_A_LEFT);
	wire         wa_r = wr_smp && (grp == `GRP_A_RIGHT);
	wire         wb_l = wr_smp && (grp == `GRP_MID_LEFT);
	wire         wb_r = wr_smp && (grp == `GRP_MID_RIGHT);
	wire         wc   = wr_smp && (grp == `GRP_PACKED);

	always @* begin
		src_l  = {rx_data_l & {5{mask}}, 20'h0, wr_single, wr_single,
		          20'h0};
		src_r  = {rx_data_r & {5{mask}}, 20'h0, wr_single, wr_single,
		          20'h0};
		src_sl = {rx_stb_l, 1'b0, wb_l, wa_l, 1'b0};
		src_sr = {rx_stb_r, 1'b0, wb_r, wa_r, 1'b0};
	end

	// ------------------------------------------------------------
	// Input pair alignment after overrun
	// ------------------------------------------------------------
	reg  [2:0] skip_l_reg;
	reg  [2:0] skip_r_reg;
	reg  [2:0] in_wl;
	reg  [2:0] in_wr;
	reg  [2:0] skip_l_next;
	reg  [2:0] skip_r_next;
	reg  [3:0] sel;
	integer    k;
	integer    j;
	integer    m;

	always @* begin
		sel         = `SRC_OFF;
		in_wl       = 3'h0;
		in_wr       = 3'h0;
		skip_l_next = skip_l_reg;
		skip_r_next = skip_r_reg;
		push        = 12'h0;
		push_data   = 240'h0;
		for (k = 0; k < 3; k = k + 1) begin
			sel = (k == 0) ? sel_a : (k == 1) ? sel_b : sel_c;
			if ((sel != `SRC_OFF) && (sel <= `SRC_LAST)) begin
				in_wl[k] = src_sl[sel];
				in_wr[k] = src_sr[sel];
				push_data[k*40 +: 20]      = src_l[sel*20 +: 20];
				push_data[k*40 + 20 +: 20] = src_r[sel*20 +: 20];
			end
			// A suppressed write consumes the pending skip
			if (in_wl[k] && skip_l_reg[k])
				skip_l_next[k] = 1'b0;
			else
				push[k*2] = in_wl[k];
			if (in_wr[k] && skip_r_reg[k])
				skip_r_next[k] = 1'b0;
			else
				push[k*2+1] = in_wr[k];
			// Overrun arms a skip on the other half; set wins
			if (push[k*2+1] && full[k*2+1])
				skip_l_next[k] = 1'b1;
			if (push[k*2] && full[k*2])
				skip_r_next[k] = 1'b1;
		end
		// Output FIFOs take processor writes
		push[6]  = wa_l;
		push[7]  = wa_r;
		push[8]  = wb_l;
		push[9]  = wb_r;
		push[10] = wc;
		push[11] = wc;
		push_data[6*20 +: 20]  = wr_single;
		push_data[7*20 +: 20]  = wr_single;
		push_data[8*20 +: 20]  = wr_single;
		push_data[9*20 +: 20]  = wr_single;
		push_data[10*20 +: 20] = wr_pk_l;
		push_data[11*20 +: 20] = wr_pk_r;
	end

	// ------------------------------------------------------------
	// Transmit side reads with underrun alignment
	// ------------------------------------------------------------
	reg  [2:0] blk_l_reg;
	reg  [2:0] blk_r_reg;
	reg  [2:0] blk_l_next;
	reg  [2:0] blk_r_next;
	reg  [5:0] tx_pop;

	always @* begin
		blk_l_next = blk_l_reg;
		blk_r_next = blk_r_reg;
		tx_pop     = 6'h0;
		for (j = 0; j < 3; j = j + 1) begin
			if (tx_rd_l[j] && blk_l_reg[j])
				blk_l_next[j] = 1'b0;
			else
				tx_pop[j*2] = tx_rd_l[j];
			if (tx_rd_r[j] && blk_r_reg[j])
				blk_r_next[j] = 1'b0;
			else
				tx_pop[j*2+1] = tx_rd_r[j];
			if (tx_pop[j*2+1] && empty[6 + j*2 + 1])
				blk_l_next[j] = 1'b1;
			if (tx_pop[j*2] && empty[6 + j*2])
				blk_r_next[j] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Processor reads
	// ------------------------------------------------------------
	reg  [31:0] rdata_next;
	reg  [19:0] smp;

	function [31:0] fmt_single;
		input [19:0] s;
		begin
			fmt_single = {~s[19], s[19], s[19], s[18:0], 10'h0};
		end
	endfunction

	always @* begin
		pop        = {tx_pop, 6'h0};
		rdata_next = 32'h0;
		smp        = 20'h0;
		if (rd_smp) begin
			case (grp)
				`GRP_A_LEFT, `GRP_A_RIGHT: begin
					pop[grp[0]] = 1'b1;
					smp = head[grp[0]*20 +: 20] & mask;
					if (!ctl_reg[`CTL_A_ZERO])
						rdata_next = fmt_single(smp);
				end
				`GRP_MID_LEFT, `GRP_MID_RIGHT: begin
					pop[4 + grp[0]] = 1'b1;
					smp = head[(4 + grp[0])*20 +: 20] & mask;
					if (!ctl_reg[`CTL_C_ZERO])
						rdata_next = fmt_single(smp);
				end
				`GRP_PACKED: begin
					pop[2] = 1'b1;
					pop[3] = 1'b1;
					if (!ctl_reg[`CTL_B_ZERO])
						rdata_next = {head[59:44], head[79:64]};
				end
				default: rdata_next = 32'h0;
			endcase
		end else if (rd_en && (addr == `ADDR_SOURCE_CONTROL)) begin
			rdata_next = {8'h0, ctl_reg};
		end else if (rd_en && (addr == `ADDR_FIFO_STATUS)) begin
			rdata_next = {11'h0, in_full, fill[17:0]};
		end else if (rd_en && (addr == `ADDR_SAMPLE_WIDTH)) begin
			rdata_next = {30'h0, width_reg};
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (reset) begin
			ctl_reg    <= `CTL_RESET;
			width_reg  <= `WIDTH_20;
			rdata      <= 32'h0;
			skip_l_reg <= 3'h0;
			skip_r_reg <= 3'h0;
			blk_l_reg  <= 3'h0;
			blk_r_reg  <= 3'h0;
			tx_data_l  <= 60'h0;
			tx_data_r  <= 60'h0;
		end else begin
			rdata      <= rdata_next;
			skip_l_reg <= skip_l_next;
			skip_r_reg <= skip_r_next;
			blk_l_reg  <= blk_l_next;
			blk_r_reg  <= blk_r_next;
			if (wr_en && (addr == `ADDR_SOURCE_CONTROL))
				ctl_reg <= wdata[23:0];
			if (wr_en && (addr == `ADDR_SAMPLE_WIDTH))
				width_reg <= wdata[1:0];
			for (m = 0; m < 3; m = m + 1) begin
				if (tx_pop[m*2] && !empty[6 + m*2])
					tx_data_l[m*20 +: 20] <= head[(6 + m*2)*20 +: 20];
				if (tx_pop[m*2+1] && !empty[7 + m*2])
					tx_data_r[m*20 +: 20] <= head[(7 + m*2)*20 +: 20];
			end
		end
	end

endmodule // sample_exchange

// >>> inc/sample_exchange_consts.vh
// Offsets, field positions and sizes of the processor sample exchange
`ifndef SAMPLE_EXCHANGE_CONSTS_VH
`define SAMPLE_EXCHANGE_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_SOURCE_CONTROL  8'h30
`define ADDR_SAMPLE_FIRST    8'h34
`define ADDR_SAMPLE_LAST     8'h83
`define ADDR_FIFO_STATUS     8'h84
`define ADDR_SAMPLE_WIDTH    8'h88

// Four-word groups above ADDR_SAMPLE_FIRST
`define GRP_A_LEFT           3'h0
`define GRP_A_RIGHT          3'h1
`define GRP_MID_LEFT         3'h2
`define GRP_MID_RIGHT        3'h3
`define GRP_PACKED           3'h4

// ----------------------------------------------------------------
// Source control fields and reset value
// ----------------------------------------------------------------
`define CTL_RESET            24'h000000
`define CTL_A_SEL_LO         2
`define CTL_A_SEL_HI         12
`define CTL_B_SEL_LO         5
`define CTL_B_SEL_HI         13
`define CTL_C_SEL_LO         19
`define CTL_A_THR_LO         6
`define CTL_B_THR_LO         14
`define CTL_C_THR_LO         20
`define CTL_A_RST            8
`define CTL_B_RST            9
`define CTL_C_RST            22
`define CTL_A_ZERO           10
`define CTL_B_ZERO           11
`define CTL_C_ZERO           23

// Source selector codes
`define SRC_OFF              4'h0
`define SRC_OUT_A            4'h1
`define SRC_OUT_B            4'h2
`define SRC_RX_FIRST         4'h4
`define SRC_LAST             4'h8

// Full-level thresholds for codes 00..11
`define THR_0                3'h1
`define THR_1                3'h2
`define THR_2                3'h3
`define THR_3                3'h6

// ----------------------------------------------------------------
// Sample and FIFO sizes
// ----------------------------------------------------------------
`define SAMPLE_BITS          20
`define FIFO_DEPTH           3'h6
`define FIFO_LAST            3'h5
`define WIDTH_20             2'h0
`define WIDTH_18             2'h1
`define WIDTH_16             2'h2
`define MASK_20              20'hfffff
`define MASK_18              20'hffffc
`define MASK_16              20'hffff0

`endif

// >>> tb/sample_exchange_monitor.sv
// Port assertions for the sample exchange
`timescale 1ns/1ps
module sample_exchange_monitor (
	input wire        ref_clk,   // Clock
	input wire        reset,     // Sync reset
	input wire [7:0]  addr,      // Address
	input wire        wr_en,     // Write strobe
	input wire        rd_en,     // Read strobe
	input wire [31:0] rdata,     // Read data
	input wire [4:0]  rx_stb_l,  // Left pushes
	input wire [2:0]  tx_rd_l,   // Left pulls
	input wire [2:0]  tx_rd_r,   // Right pulls
	input wire [59:0] tx_data_l, // Left out
	input wire [59:0] tx_data_r, // Right out
	input wire [2:0]  in_full    // Full flags
);
wire single_rd = rd_en && addr >= 8'h34 && addr < 8'h74;
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (reset);

a_low_bits_zero: assert property (single_rd |=> rdata[9:0] == 10'h0)
	else $error("low sample bits not zero");
a_msb_copied: assert property (single_rd |=> rdata[30] == rdata[29])
	else $error("msb copies differ");
a_msb_inverted: assert property (single_rd |=>
	rdata == 32'h0 || rdata[31] != rdata[30])
	else $error("top bit not inverted msb");
a_full_a_cause: assert property ($rose(in_full[0]) |->
	$past(rx_stb_l) != 5'h0 || $past(wr_en))
	else $error("full a raised without push");
a_full_b_cause: assert property ($rose(in_full[1]) |->
	$past(rx_stb_l) != 5'h0 || $past(wr_en))
	else $error("full b raised without push");
a_full_drop_cause: assert property ($fell(in_full[0]) |->
	$past(rd_en) || $past(wr_en) || $past(wr_en, 2))
	else $error("full a dropped without access");
a_left_out_hold: assert property (tx_rd_l == 3'h0 |=>
	$stable(tx_data_l))
	else $error("left output moved without pull");
a_right_out_hold: assert property (tx_rd_r == 3'h0 |=>
	$stable(tx_data_r))
	else $error("right output moved without pull");
endmodule // sample_exchange_monitor

bind sample_exchange sample_exchange_monitor sample_exchange_monitor_inst (
	.ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .rx_stb_l(rx_stb_l),
	.tx_rd_l(tx_rd_l), .tx_rd_r(tx_rd_r), .tx_data_l(tx_data_l),
	.tx_data_r(tx_data_r), .in_full(in_full));

// >>> tb/audio_far_end.sv
// Audio-side receivers and transmitters facing the sample exchange
`timescale 1ns/1ps
module audio_far_end (
	input  wire        ref_clk,   // Clock
	output reg  [99:0] rx_data_l, // Receiver left samples
	output reg  [99:0] rx_data_r, // Receiver right samples
	output reg  [4:0]  rx_stb_l,  // Left push strobes
	output reg  [4:0]  rx_stb_r,  // Right push strobes
	output reg  [2:0]  tx_rd_l,   // Left read strobes
	output reg  [2:0]  tx_rd_r    // Right read strobes
);
initial begin
	rx_data_l = 100'h0;
	rx_data_r = 100'h0;
	rx_stb_l = 5'h0;
	rx_stb_r = 5'h0;
	tx_rd_l = 3'h0;
	tx_rd_r = 3'h0;
end
// Push one sample pair; half[1] left, half[0] right
task push(input integer k, input [19:0] l, input [19:0] r,
	input [1:0] half);
	@(posedge ref_clk);
	rx_data_l[k*20 +: 20] <= l;
	rx_data_r[k*20 +: 20] <= r;
	rx_stb_l[k] <= half[1];
	rx_stb_r[k] <= half[0];
	@(posedge ref_clk);
	rx_stb_l <= 5'h0;
	rx_stb_r <= 5'h0;
	// Idle data never repeats the sample just sent
	rx_data_l <= ~rx_data_l;
	rx_data_r <= ~rx_data_r;
	#1;
endtask
task pull(input integer k, input [1:0] half);
	@(posedge ref_clk);
	tx_rd_l[k] <= half[1];
	tx_rd_r[k] <= half[0];
	@(posedge ref_clk);
	tx_rd_l <= 3'h0;
	tx_rd_r <= 3'h0;
	#1;
endtask
endmodule // audio_far_end

// >>> tb/testbench.sv
// Self-checking bench for the sample exchange
`timescale 1ns/1ps
module testbench;
reg         ref_clk, reset, wr_en, rd_en;
reg  [7:0]  addr;
reg  [31:0] wdata;
wire [31:0] rdata;
wire [99:0] rx_data_l, rx_data_r;
wire [4:0]  rx_stb_l, rx_stb_r;
wire [2:0]  tx_rd_l, tx_rd_r, in_full;
wire [59:0] tx_data_l, tx_data_r;
integer     error_cnt, total_checks, i, k;

sample_exchange sample_exchange_inst (.ref_clk(ref_clk), .reset(reset),
	.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
	.rdata(rdata), .rx_data_l(rx_data_l), .rx_data_r(rx_data_r),
	.rx_stb_l(rx_stb_l), .rx_stb_r(rx_stb_r), .tx_rd_l(tx_rd_l),
	.tx_rd_r(tx_rd_r), .tx_data_l(tx_data_l), .tx_data_r(tx_data_r),
	.in_full(in_full));
audio_far_end audio_far_end_inst (.ref_clk(ref_clk),
	.rx_data_l(rx_data_l), .rx_data_r(rx_data_r), .rx_stb_l(rx_stb_l),
	.rx_stb_r(rx_stb_r), .tx_rd_l(tx_rd_l), .tx_rd_r(tx_rd_r));

initial begin
	ref_clk = 1'b0;
	forever #5 ref_clk = ~ref_clk;
end

function [31:0] fmt(input [19:0] s);
	fmt = {~s[19], s[19], s[19], s[18:0], 10'h0};
endfunction
task check(input [31:0] seen, input [31:0] exp);
	total_checks = total_checks + 1;
	if (seen !== exp) begin
		error_cnt = error_cnt + 1;
		$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask
task wr(input [7:0] a, input [31:0] d);
	@(posedge ref_clk);
	wr_en <= 1'b1;
	addr <= a;
	wdata <= d;
	@(posedge ref_clk);
	wr_en <= 1'b0;
	#1;
endtask
task rc(input [7:0] a, input [31:0] exp);
	@(posedge ref_clk);
	rd_en <= 1'b1;
	addr <= a;
	@(posedge ref_clk);
	rd_en <= 1'b0;
	#1 check(rdata, exp);
endtask
task txc(input [19:0] l, input [19:0] r);
	check({12'h0, tx_data_l[19:0]}, {12'h0, l});
	check({12'h0, tx_data_r[19:0]}, {12'h0, r});
endtask
task end_sim;
	$display("checks=%0d errors=%0d", total_checks, error_cnt);
	if (error_cnt == 0 && total_checks > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask

task t_full;
	integer c, n;
	for (c = 0; c < 4; c = c + 1) begin
		wr(8'h30, (c << 6) | (c + 4));
		n = (c == 3) ? 6 : c + 1;
		for (k = 0; k < n; k = k + 1) begin
			check({29'h0, in_full}, 32'h0);
			audio_far_end_inst.push(c, 20'h80000 + k, 20'h7fff0 - k, 2'b11);
		end
		check({29'h0, in_full}, 32'h1);
		for (k = 0; k < n; k = k + 1) begin
			rc(8'h34 + {k[1:0], 2'b0}, fmt(20'h80000 + k));
			rc(8'h44, fmt(20'h7fff0 - k));
		end
		check({29'h0, in_full}, 32'h0);
	end
	$display("full levels done");
endtask
task t_zero;
	wr(8'h30, 32'h1c20);
	audio_far_end_inst.push(4, 20'h12345, 20'h54321, 2'b11);
	audio_far_end_inst.push(0, 20'h11111, 20'h22222, 2'b11);
	rc(8'h34, 32'h0);
	rc(8'h44, 32'h0);
	rc(8'h74, 32'h0);
	wr(8'h30, 32'h1);
	wr(8'h3c, fmt(20'h5a5a5));
	rc(8'h34, fmt(20'h5a5a5));
	audio_far_end_inst.pull(0, 2'b10);
	check({12'h0, tx_data_l[19:0]}, 32'h5a5a5);
	wr(8'h30, 32'h0);
	audio_far_end_inst.push(0, 20'h1, 20'h2, 2'b11);
	rc(8'h84, 32'h0);
	$display("zero control done");
endtask
task t_packed;
	wr(8'h30, 32'h28);
	audio_far_end_inst.push(1, 20'habcde, 20'h12345, 2'b11);
	rc(8'h78, 32'habcd1234);
	$display("packed done");
endtask
task t_trim;
	wr(8'h30, 32'h24);
	for (k = 0; k < 6; k = k + 1)
		audio_far_end_inst.push(0, 20'h10 + k, 20'h20 + k, 2'b11);
	rc(8'h84, 32'h000c0db6);
	wr(8'h30, 32'h324);
	wr(8'h30, 32'h24);
	rc(8'h84, 32'h000c0249);
	rc(8'h34, fmt(20'h10));
	rc(8'h44, fmt(20'h20));
	rc(8'h74, 32'h00010002);
	$display("fifo trim done");
endtask
task t_overrun;
	wr(8'h30, 32'h4);
	for (k = 0; k < 6; k = k + 1)
		audio_far_end_inst.push(0, 20'h100 + k, 20'h200 + k, 2'b11);
	audio_far_end_inst.push(0, 20'h1fe, 20'h2fe, 2'b01);
	rc(8'h34, fmt(20'h100));
	rc(8'h44, fmt(20'h200));
	audio_far_end_inst.push(0, 20'h1ff, 20'h2ff, 2'b11);
	rc(8'h84, 32'h00040035);
	audio_far_end_inst.push(0, 20'h1fd, 20'h2fd, 2'b10);
	audio_far_end_inst.push(0, 20'h1fc, 20'h2fc, 2'b10);
	rc(8'h34, fmt(20'h101));
	rc(8'h44, fmt(20'h201));
	audio_far_end_inst.push(0, 20'h1fb, 20'h2fb, 2'b11);
	rc(8'h84, 32'h0004002e);
	@(posedge ref_clk);
	reset <= 1'b1;
	// Three edges, so flags cleared by reset have settled at release
	repeat (3) @(posedge ref_clk);
	reset <= 1'b0;
	rc(8'h84, 32'h0);
	$display("overrun done");
endtask
task t_out;
	for (i = 0; i < 4; i = i + 1)
		wr(8'h34 + {i[1:0], 2'b0}, fmt(20'hc0000 + i));
	wr(8'h44, fmt(20'h30000));
	audio_far_end_inst.pull(0, 2'b11);
	txc(20'hc0000, 20'h30000);
	audio_far_end_inst.pull(0, 2'b01);
	wr(8'h48, fmt(20'h30001));
	audio_far_end_inst.pull(0, 2'b11);
	txc(20'hc0000, 20'h30001);
	for (i = 1; i < 4; i = i + 1) begin
		audio_far_end_inst.pull(0, 2'b10);
		txc(20'hc0000 + i, 20'h30001);
	end
	audio_far_end_inst.pull(0, 2'b10);
	wr(8'h4c, fmt(20'h30002));
	wr(8'h38, fmt(20'hc0004));
	audio_far_end_inst.pull(0, 2'b11);
	txc(20'hc0004, 20'h30001);
	audio_far_end_inst.pull(0, 2'b01);
	txc(20'hc0004, 20'h30002);
	wr(8'h88, 32'h2);
	wr(8'h34, fmt(20'hfffff));
	audio_far_end_inst.pull(0, 2'b10);
	txc(20'hffff0, 20'h30002);
	wr(8'h88, 32'h0);
	$display("output fifo done");
endtask
task t_mid;
	wr(8'h30, 32'h20000);
	wr(8'h58, fmt(20'h4a4a4));
	wr(8'h68, fmt(20'h5b5b5));
	rc(8'h84, 32'h00109000);
	rc(8'h54, fmt(20'h4a4a4));
	rc(8'h64, fmt(20'h5b5b5));
	wr(8'h74, 32'h9abc1357);
	audio_far_end_inst.pull(1, 2'b11);
	check({12'h0, tx_data_l[39:20]}, 32'h4a4a4);
	check({12'h0, tx_data_r[39:20]}, 32'h5b5b5);
	audio_far_end_inst.pull(2, 2'b11);
	check({12'h0, tx_data_l[59:40]}, 32'h9abc0);
	check({12'h0, tx_data_r[59:40]}, 32'h13570);
	wr(8'h30, 32'h0);
	$display("mid and packed out done");
endtask

initial begin
	error_cnt = 0;
	total_checks = 0;
	reset = 1'b1;
	wr_en = 1'b0;
	rd_en = 1'b0;
	addr = 8'h0;
	wdata = 32'h0;
	repeat (12) @(posedge ref_clk);
	reset <= 1'b0;
	t_full;
	t_zero;
	t_packed;
	t_trim;
	t_overrun;
	t_out;
	t_mid;
	end_sim;
end
initial begin
	#300000;
	error_cnt = error_cnt + 1;
	end_sim;
end
endmodule // testbench
